// ---- src_pkg.sv ----
// Constants, register map and types of the system reset controller.
// Assumes a single 125 MHz system clock and a word-indexed register port.
package src_pkg;

  localparam int unsigned CLK_MHZ         = 125;
  // Internal reset is held this long after the last source goes away.
  localparam int unsigned RELEASE_NS      = 1000;
  localparam int unsigned RELEASE_CYC     = (RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 8;
  localparam logic [CNT_W-1:0] RELEASE_CNT = CNT_W'(RELEASE_CYC);

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CAUSE   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRST0   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PRST1   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_PRST2   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_ALTFN   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CORECTL = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IDENT0  = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IDENT1  = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_CAP0    = 4'h8;

  localparam int unsigned NUM_CAP   = 5;
  localparam int unsigned NUM_PRST  = 3;

  // Cause record bit positions.
  localparam int unsigned CAUSE_EXT = 0;
  localparam int unsigned CAUSE_POR = 1;
  localparam int unsigned CAUSE_BOR = 2;
  localparam int unsigned CAUSE_WDT = 3;
  localparam int unsigned CAUSE_SW  = 4;
  localparam int unsigned CAUSE_LDO = 5;
  localparam int unsigned NUM_SRC   = 6;

  localparam int unsigned SYSREQ_BIT = 2;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  typedef enum logic [1:0] {
    SRC_POWERUP = 2'b00,
    SRC_HOLD    = 2'b01,
    SRC_RELEASE = 2'b10,
    SRC_RUN     = 2'b11
  } src_state_t;

endpackage

// ---- src_sync.sv ----
// Two-stage synchroniser for a level input.
// Assumes the input may change at any time with respect to the clock.
`timescale 1ns/1ns
module src_sync
  import src_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Level in and out.
  input  wire logic dIn,
  output logic      dOut
);
  logic stage1_r;
  logic stage2_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= dIn;
      stage2_r <= stage1_r;
    end
  end

  assign dOut = stage2_r;
endmodule

// ---- src_prst.sv ----
// Per-peripheral software reset controls: a bit set and then cleared resets the module.
// Assumes write strobes arrive one cycle at a time from the register port.
`timescale 1ns/1ns
module src_prst
  import src_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Register write.
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  // State.
  output logic      [WIDTH-1:0] ctrlQ,
  output logic      [WIDTH-1:0] pulseQ
);
  logic [WIDTH-1:0] ctrl_r;
  logic [WIDTH-1:0] ctrl_nxt;
  logic [WIDTH-1:0] pulse_r;
  logic [WIDTH-1:0] pulse_nxt;

  always_comb begin
    ctrl_nxt  = ctrl_r;
    pulse_nxt = '0;
    if (wrEn) begin
      ctrl_nxt  = wrData;
      pulse_nxt = ctrl_r & ~wrData; // [R16]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= '0;
      pulse_r <= '0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign ctrlQ  = ctrl_r;
  assign pulseQ = pulse_r;

  prst_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrEn && |(ctrl_r & ~wrData)) |=> (pulse_r == $past(ctrl_r & ~wrData)))
    else $error("peripheral reset pulse wrong"); // [R16]
endmodule

// ---- src_reset_ctrl.sv ----
// System reset controller: source collection, domain decode, cause record,
// release sequencing, identification registers and alternate pin select.
// Assumes all pin and monitor inputs are synchronous except the reset pin.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ns

// Summary of operation
// R01 - Accept six reset sources
// R02 - Power-on resets core, peripherals and TAP
// R03 - Pin reset spares TAP, only pin config
// R04 - Other system resets spare the TAP
// R05 - System request bit triggers software reset
// R06 - Peripheral reset per module, nothing else
// R07 - Record the causing source after reset
// R08 - Causes sticky; pin reset clears others
// R09 - Pin/power-on on main osc, sequence internal
// R10 - Hold until power detect falls, then release
// R11 - Power-on only fires at first power-up
// R12 - Outside holds pin low minimum pulse
// R13 - Read-only identification registers
// R14 - Interrupt pin is GPIO until selected
// R15 - Power-on resets everything past threshold
// R16 - Peripheral reset on set then clear
// R17 - Synchronise pin release before internal release
module src_reset_ctrl
  import src_pkg::*;
#(
  parameter logic [31:0] IDENT0_VAL = 32'h0001_0000, // Arbitrary value.
  parameter logic [31:0] IDENT1_VAL = 32'h0002_0000, // Arbitrary value.
  parameter logic [31:0] CAP_VAL    = 32'h0000_0001,
  parameter int unsigned PRST_W     = 32
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Reset sources.
  input  wire logic              extResetPin_n,
  input  wire logic              powerOnDetect,
  input  wire logic              brownoutDetect,
  input  wire logic              watchdogReset,
  input  wire logic              coreRegulatorFault,
  // Register port.
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdData,
  // Reset outputs.
  output logic                   coreReset_n,
  output logic                   periphReset_n,
  output logic                   tapReset_n,
  output logic                   tapPinCfgReset_n,
  output logic [NUM_PRST*PRST_W-1:0] periphSwReset_n,
  output logic                   fetchVectors,
  // Interrupt pin select.
  output logic                   nmiSelect
);
  logic extSync;
  logic extSyncQ;
  logic [NUM_PRST*PRST_W-1:0] prstPulse;
  logic [NUM_PRST*PRST_W-1:0] prstCtrl;

  // Pin deassertion passes two flops before reaching release logic. [R17]
  // Its flops start at the pin's idle level, so leaving block reset is no pin reset.
  src_sync #(.RESET_VAL(1'b1)) uSync (
    .clock (clock),
    .rst_n (rst_n),
    .dIn   (extResetPin_n),
    .dOut  (extSync)
  );
  assign extSyncQ = ~extSync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRST; gi++) begin : gPrst
      src_prst #(.WIDTH(PRST_W)) uPrst (
        .clock  (clock),
        .rst_n  (rst_n),
        .wrEn   (regWrite && regAddr == ADDR_PRST0 + ADDR_W'(gi)),
        .wrData (regWrData[PRST_W-1:0]),
        .ctrlQ  (prstCtrl[gi*PRST_W +: PRST_W]),
        .pulseQ (prstPulse[gi*PRST_W +: PRST_W])
      );
    end
  endgenerate

  src_state_t             state_r;
  src_state_t             state_nxt;
  logic [CNT_W-1:0]       cnt_r;
  logic [CNT_W-1:0]       cnt_nxt;
  logic                   porSeen_r;
  logic                   porSeen_nxt;
  logic [NUM_SRC-1:0]     cause_r;
  logic [NUM_SRC-1:0]     cause_nxt;
  logic [NUM_SRC-1:0]     pend_r;
  logic [NUM_SRC-1:0]     pend_nxt;
  logic                   tapHold_r;
  logic                   tapHold_nxt;
  logic                   pinHold_r;
  logic                   pinHold_nxt;
  logic                   altFn_r;
  logic                   altFn_nxt;
  logic [31:0]            rd_r;
  logic [31:0]            rd_nxt;
  logic                   fetch_r;
  logic                   fetch_nxt;
  logic [NUM_PRST*PRST_W-1:0] swRun_r;
  logic                   coreRun_r;
  logic                   coreRun_nxt;
  logic                   tapRun_r;
  logic                   tapRun_nxt;
  logic                   pinCfgRun_r;
  logic                   pinCfgRun_nxt;
  logic [NUM_SRC-1:0]     srcNow;
  logic                   porEvt;
  logic                   swReq;

  // The power detect is honoured only until it first falls during power-up. [R11]
  assign porEvt = powerOnDetect && !porSeen_r;
  assign swReq  = regWrite && regAddr == ADDR_CORECTL && regWrData[SYSREQ_BIT]; // [R05]

  always_comb begin
    srcNow            = '0; // [R01]
    srcNow[CAUSE_EXT] = extSyncQ;
    srcNow[CAUSE_POR] = porEvt;
    srcNow[CAUSE_BOR] = brownoutDetect;
    srcNow[CAUSE_WDT] = watchdogReset;
    srcNow[CAUSE_SW]  = swReq;
    srcNow[CAUSE_LDO] = coreRegulatorFault;
  end

  // Release sequencer, run on the internal clock. [R09]
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    porSeen_nxt = porSeen_r;
    pend_nxt    = pend_r | srcNow;
    tapHold_nxt = tapHold_r;
    pinHold_nxt = pinHold_r | srcNow[CAUSE_EXT];
    cause_nxt   = cause_r;
    fetch_nxt   = 1'b0;
    case (state_r)
      SRC_POWERUP: begin
        tapHold_nxt = 1'b1; // [R02] [R15]
        if (!powerOnDetect) begin
          porSeen_nxt = 1'b1; // [R10]
          pend_nxt    = pend_nxt | (NUM_SRC'(1) << CAUSE_POR);
          state_nxt   = SRC_HOLD;
          cnt_nxt     = RELEASE_CNT;
        end
      end
      SRC_HOLD: begin
        if (|srcNow) begin
          cnt_nxt = RELEASE_CNT;
        end else if (cnt_r > CNT_W'(1)) begin
          cnt_nxt = cnt_r - CNT_W'(1);
        end else begin
          state_nxt = SRC_RELEASE;
        end
      end
      SRC_RELEASE: begin
        // Cause bits are sticky unless the pin was among the causes. [R07] [R08]
        if (pend_r[CAUSE_EXT]) begin
          cause_nxt = NUM_SRC'(1) << CAUSE_EXT;
        end else begin
          cause_nxt = cause_r | pend_r;
        end
        pend_nxt    = srcNow;
        tapHold_nxt = 1'b0;
        pinHold_nxt = 1'b0;
        fetch_nxt   = 1'b1; // [R10]
        state_nxt   = SRC_RUN;
      end
      SRC_RUN: begin
        if (|srcNow) begin
          state_nxt = SRC_HOLD;
          cnt_nxt   = RELEASE_CNT;
        end
      end
      default: begin
        state_nxt = SRC_POWERUP;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= SRC_POWERUP;
      cnt_r     <= '0;
      porSeen_r <= 1'b0;
      pend_r    <= '0;
      tapHold_r <= 1'b1;
      pinHold_r <= 1'b0;
      cause_r   <= '0;
      fetch_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      porSeen_r <= porSeen_nxt;
      pend_r    <= pend_nxt;
      tapHold_r <= tapHold_nxt;
      pinHold_r <= pinHold_nxt;
      cause_r   <= cause_nxt;
      fetch_r   <= fetch_nxt;
    end
  end

  // Reset pins leave flops loaded from the next state, so they still move in
  // the same cycle as the sequencer state and never glitch on a decode.
  always_comb begin
    coreRun_nxt   = (state_nxt == SRC_RUN);
    tapRun_nxt    = !tapHold_nxt;
    pinCfgRun_nxt = !(pinHold_nxt || tapHold_nxt);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      coreRun_r   <= 1'b0;
      tapRun_r    <= 1'b0;
      pinCfgRun_r <= 1'b0;
    end else begin
      coreRun_r   <= coreRun_nxt;
      tapRun_r    <= tapRun_nxt;
      pinCfgRun_r <= pinCfgRun_nxt;
    end
  end

  // Register port.
  always_comb begin
    altFn_nxt  = altFn_r;
    rd_nxt     = ZERO_WORD;
    if (state_r != SRC_RUN) begin
      altFn_nxt = 1'b0; // [R14]
    end else if (regWrite && regAddr == ADDR_ALTFN) begin
      altFn_nxt = regWrData[0];
    end
    if (regRead) begin
      case (regAddr)
        ADDR_CAUSE:  rd_nxt = {{(32-NUM_SRC){1'b0}}, cause_r};
        ADDR_PRST0:  rd_nxt = 32'(prstCtrl[0 +: PRST_W]);
        ADDR_PRST1:  rd_nxt = 32'(prstCtrl[PRST_W +: PRST_W]);
        ADDR_PRST2:  rd_nxt = 32'(prstCtrl[2*PRST_W +: PRST_W]);
        ADDR_ALTFN:  rd_nxt = {31'h0000_0000, altFn_r};
        ADDR_IDENT0: rd_nxt = IDENT0_VAL; // [R13]
        ADDR_IDENT1: rd_nxt = IDENT1_VAL;
        default: begin
          if (regAddr >= ADDR_CAP0 && regAddr < ADDR_CAP0 + ADDR_W'(NUM_CAP)) begin
            rd_nxt = CAP_VAL;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      altFn_r  <= 1'b0;
      rd_r     <= '0;
      swRun_r  <= '1;
    end else begin
      altFn_r  <= altFn_nxt;
      rd_r     <= rd_nxt;
      swRun_r  <= ~prstPulse; // [R06]
    end
  end

  assign regRdData        = rd_r;
  assign coreReset_n      = coreRun_r;                      // [R03] [R04]
  assign periphReset_n    = coreRun_r;
  assign tapReset_n       = tapRun_r;                       // [R02]
  assign tapPinCfgReset_n = pinCfgRun_r;                    // [R03]
  assign periphSwReset_n  = swRun_r;
  assign fetchVectors     = fetch_r;
  assign nmiSelect        = altFn_r;

  tap_spared_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($past(state_r) == SRC_RUN && state_r == SRC_HOLD) |-> tapReset_n)
    else $error("tap reset by non power source"); // [R04]
  por_once_a: assert property (@(posedge clock) disable iff (!rst_n)
    porSeen_r |=> porSeen_r)
    else $error("power-on seen flag dropped"); // [R11]
  pin_cause_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == SRC_RELEASE && pend_r[CAUSE_EXT]) |=> cause_r == 6'h01)
    else $error("pin cause did not clear others"); // [R08]
  cause_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == SRC_RELEASE && !pend_r[CAUSE_EXT]) |=>
    ((cause_r & $past(pend_r)) == $past(pend_r)))
    else $error("cause not recorded"); // [R07]
  hold_por_a: assert property (@(posedge clock) disable iff (!rst_n)
    powerOnDetect && state_r == SRC_POWERUP |-> !coreReset_n && !tapReset_n)
    else $error("released during power-on"); // [R10]
  fetch_after_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(coreReset_n) |-> fetchVectors)
    else $error("no vector fetch on release"); // [R10]
  sw_req_a: assert property (@(posedge clock) disable iff (!rst_n)
    (swReq && state_r == SRC_RUN) |=> !coreReset_n && !periphReset_n)
    else $error("software request ignored"); // [R05]
  pin_sync_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_r == SRC_RUN && !extResetPin_n) |-> ##3 !coreReset_n)
    else $error("pin reset missed"); // [R03]
  nmi_gpio_a: assert property (@(posedge clock) disable iff (!rst_n)
    !coreReset_n |=> !nmiSelect)
    else $error("alternate function survived reset"); // [R14]

  por_done_c: cover property (@(posedge clock) disable iff (!rst_n)
    $fell(powerOnDetect) ##[1:300] fetchVectors);
  pin_rst_c: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == SRC_RUN ##1 !extResetPin_n ##[1:300] fetchVectors);
  wdt_rst_c: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == SRC_RUN && watchdogReset);
  prst_c: cover property (@(posedge clock) disable iff (!rst_n) |prstPulse);
endmodule

// ---- src_partner.sv ----
// Model of the far side: reset pin with pull-up, supply monitors and the core.
// Assumes the bench calls its tasks and shares the one system clock.
`timescale 1ns/1ns
module src_partner #(
  parameter int unsigned MIN_PULSE = 8
) (
  // Clock and core side.
  input  wire logic clock,
  input  wire logic fetchVectors,
  // Reset sources.
  output logic      extResetPin_n,
  output logic      powerOnDetect,
  output logic      brownoutDetect,
  output logic      watchdogReset,
  output logic      coreRegulatorFault
);
  int nFetch;

  // Supply starts ramping, so the power-on detector is high at time zero.
  initial begin
    extResetPin_n = 1'b1;
    powerOnDetect = 1'b1;
    brownoutDetect = 1'b0;
    watchdogReset = 1'b0;
    coreRegulatorFault = 1'b0;
    nFetch = 0;
  end

  // The core counts each vector fetch it is allowed to make.
  always @(posedge clock) begin
    if (fetchVectors === 1'b1) begin
      nFetch <= nFetch + 1;
    end
  end

  // Drives the power-on detector, high for as long as the supply ramps.
  task set_por(input logic v);
    @(posedge clock);
    powerOnDetect <= v;
  endtask

  // Raises one source: 0 pin, 2 brown-out, 3 watchdog, 5 regulator fault.
  task pulse(input int idx);
    @(posedge clock);
    case (idx)
      0: extResetPin_n <= 1'b0;
      2: brownoutDetect <= 1'b1;
      3: watchdogReset <= 1'b1;
      default: coreRegulatorFault <= 1'b1;
    endcase
    repeat (MIN_PULSE) @(posedge clock);
    // The pin returns to its pull-up level once released.
    extResetPin_n <= 1'b1;
    brownoutDetect <= 1'b0;
    watchdogReset <= 1'b0;
    coreRegulatorFault <= 1'b0;
  endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the system reset controller.
// Assumes the partner model drives all reset sources except the software request, which the bench writes.
`timescale 1ns/1ns
module tb;
  import src_pkg::*;
  logic                clock;
  logic                rst_n;
  logic                extResetPin_n;
  logic                powerOnDetect;
  logic                brownoutDetect;
  logic                watchdogReset;
  logic                coreRegulatorFault;
  logic [ADDR_W-1:0]   regAddr;
  logic [31:0]         regWrData;
  logic                regWrite;
  logic                regRead;
  logic [31:0]         regRdData;
  logic                coreReset_n;
  logic                periphReset_n;
  logic                tapReset_n;
  logic                tapPinCfgReset_n;
  logic [NUM_PRST*32-1:0] periphSwReset_n;
  logic                fetchVectors;
  logic                nmiSelect;
  logic [31:0]         d;
  int                  n_errors;
  int                  n_checks;

  src_reset_ctrl uut (.clock(clock), .rst_n(rst_n), .extResetPin_n(extResetPin_n),
    .powerOnDetect(powerOnDetect), .brownoutDetect(brownoutDetect),
    .watchdogReset(watchdogReset), .coreRegulatorFault(coreRegulatorFault),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .coreReset_n(coreReset_n), .periphReset_n(periphReset_n),
    .tapReset_n(tapReset_n), .tapPinCfgReset_n(tapPinCfgReset_n),
    .periphSwReset_n(periphSwReset_n), .fetchVectors(fetchVectors), .nmiSelect(nmiSelect));

  src_partner ptr (.clock(clock), .fetchVectors(fetchVectors), .extResetPin_n(extResetPin_n),
    .powerOnDetect(powerOnDetect), .brownoutDetect(brownoutDetect),
    .watchdogReset(watchdogReset), .coreRegulatorFault(coreRegulatorFault));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask

  // Waits for the release pulse, then reads the cause record.
  task wait_release(input logic [5:0] cause);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 400 && !got; i++) begin
      @(posedge clock);
      #1 got = (fetchVectors === 1'b1);
    end
    check("fetch", got, 1'b1);
    check("core out", coreReset_n, 1'b1);
    @(posedge clock);
    rd(ADDR_CAUSE, d);
    check("cause", d, {26'h0, cause});
    check("tap", tapReset_n, 1'b1);
  endtask

  task test_power_up();
    #1 check("tap por", tapReset_n, 1'b0);
    check("core por", coreReset_n, 1'b0);
    check("periph por", periphReset_n, 1'b0);
    check("nmi", nmiSelect, 1'b0);
    repeat (200) @(posedge clock);
    #1 check("hold por", coreReset_n, 1'b0);
    ptr.set_por(1'b0);
    wait_release(6'b00_0010);
    $display("test power_up done");
  endtask

  // Source 4 is the software request bit; the others come from the partner.
  task test_source(input int idx, input logic [5:0] cause);
    if (idx == 4) begin
      wr(ADDR_CORECTL, 32'h0000_0004);
      repeat (3) @(posedge clock);
    end else begin
      ptr.pulse(idx);
      repeat (4) @(posedge clock);
    end
    #1 check("core", coreReset_n, 1'b0);
    check("periph", periphReset_n, 1'b0);
    check("tap", tapReset_n, 1'b1);
    check("pin cfg", tapPinCfgReset_n, idx != 0);
    wr(ADDR_ALTFN, 32'h0000_0001);
    @(posedge clock);
    #1 check("nmi held", nmiSelect, 1'b0);
    wait_release(cause);
    $display("test source %0d done", idx);
  endtask

  task test_por_again();
    ptr.set_por(1'b1);
    repeat (20) @(posedge clock);
    #1 check("por again", coreReset_n, 1'b1);
    check("tap again", tapReset_n, 1'b1);
    ptr.set_por(1'b0);
    $display("test por_again done");
  endtask

  task test_prst(input int r, input int b);
    int lows;
    int own;
    lows = 0;
    own = 0;
    wr(ADDR_PRST0 + ADDR_W'(r), 32'h0000_0001 << b);
    rd(ADDR_PRST0 + ADDR_W'(r), d);
    check("prst rd", d, 32'h0000_0001 << b);
    wr(ADDR_PRST0 + ADDR_W'(r), ZERO_WORD);
    for (int i = 0; i < 4; i++) begin
      #1 lows += $countones(~periphSwReset_n);
      own += (periphSwReset_n[r*32+b] === 1'b0);
      @(posedge clock);
    end
    check("prst own", own, 1);
    check("prst all", lows, 1);
    #1 check("prst core", {coreReset_n, tapReset_n}, 2'b11);
    $display("test prst %0d done", r);
  endtask

  task test_regs();
    rd(ADDR_IDENT0, d);
    check("ident0", d, 32'h0001_0000);
    @(posedge clock);
    #1 check("rd idle", regRdData, ZERO_WORD);
    wr(ADDR_IDENT1, 32'hFFFF_FFFF);
    rd(ADDR_IDENT1, d);
    check("ident1", d, 32'h0002_0000);
    rd(ADDR_CAP0, d);
    check("cap0", d, 32'h0000_0001);
    rd(4'hF, d);
    check("unmapped", d, ZERO_WORD);
    wr(ADDR_ALTFN, 32'h0000_0001);
    @(posedge clock);
    #1 check("nmi sel", nmiSelect, 1'b1);
    wr(ADDR_ALTFN, ZERO_WORD);
    @(posedge clock);
    #1 check("nmi gpio", nmiSelect, 1'b0);
    $display("test regs done");
  endtask

  initial begin
    #(8 * 20000);
    n_errors++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    regAddr = '0;
    regWrData = ZERO_WORD;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    test_power_up();
    test_regs();
    test_source(2, 6'b00_0110);
    test_source(3, 6'b00_1110);
    test_source(4, 6'b01_1110);
    test_source(5, 6'b11_1110);
    test_source(0, 6'b00_0001);
    test_source(3, 6'b00_1001);
    test_por_again();
    test_prst(0, 5);
    test_prst(2, 31);
    check("fetch count", ptr.nFetch, 7);
    stop_test();
  end
endmodule
